// ===== src/dio_defs.svh
// Purpose: Offsets, fields, reset values and timing for the eight-line I/O port
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// Register byte offsets
`define OFF_DIR 8'h00
`define OFF_BYTE 8'h04
`define OFF_LO 8'h08
`define OFF_HI 8'h0c
`define OFF_LINE 8'h10
`define OFF_WCMD 8'h14
`define OFF_WTMO 8'h18
`define OFF_STAT 8'h1c
`define OFF_ARB 8'h20
`define OFF_ID 8'h24

// Field positions
`define DIR_LO_BIT 0
`define DIR_HI_BIT 1
`define LINE_SEL_MSB 2
`define LINE_VAL_BIT 8
`define WK_MSB 6
`define WK_LSB 4
`define ARB_OUT_BIT 0
`define ST_READY 0
`define ST_BUSY 1
`define ST_TMO 2
`define ST_DONE 3
`define ST_ERRVAL 4

// Wait kinds
`define WK_ANY 3'h0
`define WK_FALL 3'h1
`define WK_RISE 3'h2
`define WK_HIGH 3'h3
`define WK_LOW 3'h4

// Reset values
`define DIR_RST 2'h0
`define OUT_RST 8'h00
`define TMO_RST 32'h00000000

// Timing
`define CLK_MHZ 125
`define ERR_SETTLE_MS 2000
`define READY_NS 1000
`define READY_CYC ((`READY_NS * `CLK_MHZ) / 1000)
`define ERR_SETTLE_CYC (`ERR_SETTLE_MS * `CLK_MHZ * 1000)

`endif

// ===== src/dio_pkg.sv
// Purpose: Types shared by the eight-line I/O port
// Assumes: Nothing beyond the defs header
// Notes: Types only
package dio_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [31:0] word_t;
    typedef logic [7:0] addr_t;
    typedef enum {W_IDLE, W_RUN} wait_state_t;
endpackage

// ===== src/digital_io_port_8ch.sv
// Purpose: Eight-line bidirectional I/O port with waits and ready status, APB registers
// Assumes: pclk 125 MHz, ce freezes all state, pins synchronous inputs
// Notes: One APB wait state on every access; wait-result reads stall until the wait ends
// What this block does
// - Data writes never change line direction
// - Eight lines, zero to seven, read or write
// - Low nibble: line three MSB, zero LSB
// - High nibble: line seven MSB, four LSB
// - Byte port: line seven MSB, zero LSB
// - Output arbitration selectable, default none; inputs none
// - Signed timeout: zero immediate, negative forever
// - Either-edge wait ends on any transition
// - Falling-edge wait ends on high-to-low
// - Rising-edge wait ends on low-to-high
// - High-level wait, immediate if already high
// - Low-level wait, immediate if already low
// - Direction is set per whole port
// - Status returns one ready flag
// - Error report unreliable two seconds after reset
// - Reads while not ready are invalid
// - Output data writes while not ready are dropped
// - Loop-time disturbances stop I/O, drop ready
// - Input and output sync stages configurable
// - Ports start as inputs unless configured
// - Run-time direction replaces initial direction
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "dio_defs.svh"

module digital_io_port_8ch #(
    parameter int unsigned IN_SYNC = 2,
    parameter int unsigned OUT_SYNC = 1,
    parameter logic [1:0] INIT_DIR = `DIR_RST,
    parameter int unsigned ERR_SETTLE_CYC = `ERR_SETTLE_CYC,
    parameter logic [31:0] MODULE_ID = 32'h0000a5a5 // Arbitrary value
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire dio_pkg::addr_t paddr,
    input wire dio_pkg::word_t pwdata,
    output dio_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    // Loop side
    input wire logic loop_active,
    input wire logic loop_wr_en,
    input wire dio_pkg::byte_t loop_wr_data,
    input wire logic module_absent,
    output dio_pkg::byte_t loop_in,
    output logic loop_in_valid,
    output logic ready,
    // Pins
    input wire dio_pkg::byte_t io_line_n_in,
    output dio_pkg::byte_t io_line_n_out,
    output dio_pkg::byte_t io_line_n_oe
);
    import dio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [1:0] dir_q;
    byte_t out_q;
    logic arb_q;
    logic pend_q;
    byte_t pend_data_q;
    word_t tmo_q;
    logic [2:0] wline_q;
    logic [2:0] wkind_q;
    logic [2:0] rline_q;
    wait_state_t wst_q;
    logic [31:0] wcnt_q;
    logic wtmo_q;
    logic wdone_q;
    logic prev_q;
    logic [15:0] rdy_cnt_q;
    logic rdy_q;
    logic fault_q;
    logic [31:0] err_cnt_q;
    logic err_ok_q;
    word_t prdata_q;
    logic pready_q;
    logic pslverr_q;
    byte_t loop_in_q;
    logic loop_in_valid_q;
    byte_t isync_q [IN_SYNC];
    byte_t osync_q [OUT_SYNC];
    byte_t oesync_q [OUT_SYNC];

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire acc = ce & psel & penable;
    wire wait_rd = (paddr == `OFF_WCMD) & ~pwrite & (wst_q == W_RUN);
    wire fin = acc & pready_q;
    wire wr = fin & pwrite;
    wire rd = fin & ~pwrite;
    wire hit_dir = paddr == `OFF_DIR;
    wire hit_byte = paddr == `OFF_BYTE;
    wire hit_lo = paddr == `OFF_LO;
    wire hit_hi = paddr == `OFF_HI;
    wire hit_line = paddr == `OFF_LINE;
    wire hit_wcmd = paddr == `OFF_WCMD;
    wire hit_wtmo = paddr == `OFF_WTMO;
    wire hit_stat = paddr == `OFF_STAT;
    wire hit_arb = paddr == `OFF_ARB;
    wire hit_id = paddr == `OFF_ID;
    wire mapped = hit_dir | hit_byte | hit_lo | hit_hi | hit_line | hit_wcmd | hit_wtmo | hit_stat | hit_arb | hit_id;
    wire [2:0] wsel = pwdata[`LINE_SEL_MSB:0];
    wire [2:0] wk_new = pwdata[`WK_MSB:`WK_LSB];

    // Synced pins, last stage only
    wire byte_t pins = isync_q[IN_SYNC-1];
    // Per-port enable expanded to lines
    wire byte_t oe_lines = {{4{dir_q[`DIR_HI_BIT]}}, {4{dir_q[`DIR_LO_BIT]}}};
    // Disturbance while loop I/O runs
    wire disturb = loop_active & ((wr & hit_dir) | (rd & hit_id) | module_absent);

    // Output data image for the APB write in flight
    byte_t apb_out;
    always_comb begin
        apb_out = out_q;
        if (hit_byte) begin
            apb_out = pwdata[7:0];
        end else if (hit_lo) begin
            apb_out = {out_q[7:4], pwdata[3:0]};
        end else if (hit_hi) begin
            apb_out = {pwdata[3:0], out_q[3:0]};
        end else if (hit_line) begin
            apb_out[wsel] = pwdata[`LINE_VAL_BIT];
        end
    end
    wire apb_out_wr = wr & (hit_byte | hit_lo | hit_hi | hit_line);

    ////////////////////////////////////////////////////////////////////////
    // Wait engine helpers
    wire cur = pins[wline_q];
    wire rise = ~prev_q & cur;
    wire fall = prev_q & ~cur;
    logic hit_cond;
    always_comb begin
        case (wkind_q)
            `WK_ANY: hit_cond = rise | fall;
            `WK_FALL: hit_cond = fall;
            `WK_RISE: hit_cond = rise;
            `WK_HIGH: hit_cond = cur;
            `WK_LOW: hit_cond = ~cur;
            default: hit_cond = 1'b1;
        endcase
    end
    wire forever_wait = tmo_q[31];
    wire expire = ~forever_wait & (wcnt_q == 32'h00000000);
    wire start = wr & hit_wcmd;

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    word_t rmux;
    always_comb begin
        rmux = 32'h00000000;
        if (hit_dir) begin
            rmux = {30'h00000000, dir_q};
        end else if (hit_byte) begin
            rmux = {24'h000000, rdy_q ? pins : 8'h00};
        end else if (hit_lo) begin
            rmux = {28'h0000000, rdy_q ? pins[3:0] : 4'h0};
        end else if (hit_hi) begin
            rmux = {28'h0000000, rdy_q ? pins[7:4] : 4'h0};
        end else if (hit_line) begin
            rmux = {31'h00000000, rdy_q & pins[rline_q]};
        end else if (hit_wcmd) begin
            rmux = {28'h0000000, wdone_q, wtmo_q, 2'h0};
        end else if (hit_wtmo) begin
            rmux = tmo_q;
        end else if (hit_stat) begin
            rmux[`ST_READY] = rdy_q;
            rmux[`ST_BUSY] = wst_q == W_RUN;
            rmux[`ST_TMO] = wtmo_q;
            rmux[`ST_DONE] = wdone_q;
            rmux[`ST_ERRVAL] = err_ok_q;
        end else if (hit_arb) begin
            rmux = {31'h00000000, arb_q}; // Input policy bit is fixed at zero
        end else if (hit_id) begin
            rmux = MODULE_ID;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, longer while a wait result is pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            pready_q <= psel & penable & ~pready_q & ~wait_rd;
            prdata_q <= rmux;
            pslverr_q <= psel & penable & ~pready_q & ~wait_rd & ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction, arbitration and timeout registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= `DIR_RST;
            arb_q <= 1'b0;
            tmo_q <= `TMO_RST;
            rline_q <= 3'h0;
        end else if (ce) begin
            if (wr & hit_dir) begin
                dir_q <= pwdata[1:0];
            end else if (rdy_cnt_q == 16'h0001 && !rdy_q && !fault_q) begin
                dir_q <= INIT_DIR;
            end
            if (wr & hit_arb) begin
                arb_q <= pwdata[`ARB_OUT_BIT];
            end
            if (wr & hit_wtmo) begin
                tmo_q <= pwdata;
            end
            if (wr & hit_line) begin
                rline_q <= wsel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output data with two writers
    // Never-arbitrate lets the loop write win a collision; arbitrate queues it one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= `OUT_RST;
            pend_q <= 1'b0;
            pend_data_q <= `OUT_RST;
        end else if (ce) begin
            pend_q <= 1'b0;
            if (!rdy_q) begin
                out_q <= out_q;
            end else if (arb_q && apb_out_wr && loop_wr_en) begin
                out_q <= apb_out;
                pend_q <= 1'b1;
                pend_data_q <= loop_wr_data;
            end else if (loop_wr_en) begin
                out_q <= loop_wr_data;
            end else if (apb_out_wr) begin
                out_q <= apb_out;
            end else if (pend_q) begin
                out_q <= pend_data_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready, fault and error-report settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_cnt_q <= 16'(`READY_CYC);
            rdy_q <= 1'b0;
            fault_q <= 1'b0;
            err_cnt_q <= 32'h00000000;
            err_ok_q <= 1'b0;
        end else if (ce) begin
            if (disturb) begin
                fault_q <= 1'b1;
            end else if (!loop_active) begin
                fault_q <= 1'b0;
            end
            if (rdy_cnt_q != 16'h0000) begin
                rdy_cnt_q <= rdy_cnt_q - 16'h0001;
            end
            rdy_q <= (rdy_cnt_q == 16'h0000) & ~fault_q & ~disturb;
            if (err_cnt_q != ERR_SETTLE_CYC) begin
                err_cnt_q <= err_cnt_q + 32'h00000001;
            end
            err_ok_q <= err_cnt_q == ERR_SETTLE_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wst_q <= W_IDLE;
            wline_q <= 3'h0;
            wkind_q <= `WK_ANY;
            wcnt_q <= 32'h00000000;
            wtmo_q <= 1'b0;
            wdone_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= cur;
            case (wst_q)
                W_IDLE: begin
                    if (start) begin
                        wst_q <= W_RUN;
                        wline_q <= wsel;
                        wkind_q <= wk_new;
                        wcnt_q <= tmo_q;
                        prev_q <= pins[wsel];
                        wtmo_q <= 1'b0;
                        wdone_q <= 1'b0;
                    end
                end
                W_RUN: begin
                    if (hit_cond) begin
                        wst_q <= W_IDLE;
                        wdone_q <= 1'b1;
                    end else if (expire) begin
                        wst_q <= W_IDLE;
                        wdone_q <= 1'b1;
                        wtmo_q <= 1'b1;
                    end else if (!forever_wait) begin
                        wcnt_q <= wcnt_q - 32'h00000001;
                    end
                end
                default: wst_q <= W_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronising stages; with IN_SYNC above one, the first input stage feeds only the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < IN_SYNC; i++) begin
                isync_q[i] <= 8'h00;
            end
            for (int i = 0; i < OUT_SYNC; i++) begin
                osync_q[i] <= `OUT_RST;
                oesync_q[i] <= 8'h00;
            end
            loop_in_q <= 8'h00;
            loop_in_valid_q <= 1'b0;
        end else if (ce) begin
            isync_q[0] <= io_line_n_in;
            for (int i = 1; i < IN_SYNC; i++) begin
                isync_q[i] <= isync_q[i-1];
            end
            osync_q[0] <= out_q;
            oesync_q[0] <= rdy_q ? oe_lines : 8'h00;
            for (int i = 1; i < OUT_SYNC; i++) begin
                osync_q[i] <= osync_q[i-1];
                oesync_q[i] <= oesync_q[i-1];
            end
            loop_in_q <= rdy_q ? pins : 8'h00;
            loop_in_valid_q <= rdy_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ready = rdy_q;
    assign loop_in = loop_in_q;
    assign loop_in_valid = loop_in_valid_q;
    assign io_line_n_out = osync_q[OUT_SYNC-1];
    assign io_line_n_oe = oesync_q[OUT_SYNC-1];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_dir_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wr && hit_byte |=> dir_q == $past(dir_q))
        else $error("Data write changed direction");
    chk_zero_tmo: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wst_q == W_RUN && tmo_q == 32'h00000000 && !hit_cond |=> !ce || (wtmo_q && wst_q == W_IDLE))
        else $error("Zero timeout did not expire");
    chk_rise_end: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wst_q == W_RUN && wkind_q == `WK_RISE && rise |=> wdone_q && !wtmo_q && wst_q == W_IDLE)
        else $error("Rising edge missed");
    chk_fall_end: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wst_q == W_RUN && wkind_q == `WK_FALL && fall |=> wdone_q && !wtmo_q)
        else $error("Falling edge missed");
    chk_level_now: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wst_q == W_RUN && wkind_q == `WK_HIGH && cur |=> wst_q == W_IDLE && !wtmo_q)
        else $error("High level wait did not end");
    chk_forever_wait: assert property (@(posedge pclk) disable iff (!presetn)
        ce && wst_q == W_RUN && forever_wait && !hit_cond |=> !wtmo_q)
        else $error("Negative timeout expired");
    chk_disturb_rdy: assert property (@(posedge pclk) disable iff (!presetn)
        ce && disturb |=> !rdy_q ##1 (!ce || !rdy_q || !loop_active))
        else $error("Ready stayed high after disturbance");
    chk_notready_rd: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !rdy_q |=> !loop_in_valid_q && loop_in_q == 8'h00)
        else $error("Loop data valid while not ready");
    chk_drop_write: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !rdy_q |=> out_q == $past(out_q))
        else $error("Output changed while not ready");
    chk_err_settle: assert property (@(posedge pclk) disable iff (!presetn)
        err_ok_q |-> err_cnt_q == ERR_SETTLE_CYC)
        else $error("Error report valid too early");
    chk_port_oe: assert property (@(posedge pclk) disable iff (!presetn)
        oesync_q[0][3:0] == 4'h0 || oesync_q[0][3:0] == 4'hf)
        else $error("Low port enables split");
endmodule

// ===== test/loop_partner.sv
// Purpose: Far-side loop controller and pin environment for the eight-line port
// Assumes: Bench drives the outside level of every line on ext
// Notes: Loop writes are only issued while the loop runs
`timescale 1ns/100ps
module loop_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Commands from the bench
    input wire logic want_loop,
    input wire logic wr_req,
    input wire dio_pkg::byte_t wr_val,
    input wire dio_pkg::byte_t ext,
    // Block side
    input wire logic ready,
    input wire dio_pkg::byte_t io_out,
    input wire dio_pkg::byte_t io_oe,
    output logic loop_active,
    output logic loop_wr_en,
    output dio_pkg::byte_t loop_wr_data,
    output logic module_absent,
    output dio_pkg::byte_t pins
);
    import dio_pkg::*;
    ////////////////////////////////////////////////////////////////
    // Block drive wins where enabled, else the outside driver
    assign pins = (io_oe & io_out) | (~io_oe & ext);
    // Module stays seated; removal is not exercised here
    assign module_absent = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_active <= 1'b0;
            loop_wr_en <= 1'b0;
            loop_wr_data <= 8'h00;
        end else begin
            // Loop starts only once ready is seen
            if (!want_loop) begin
                loop_active <= 1'b0;
            end else if (ready) begin
                loop_active <= 1'b1;
            end
            loop_wr_en <= wr_req & loop_active;
            // Idle data is scrambled so a stale value is never trusted
            loop_wr_data <= wr_req ? wr_val : ~loop_wr_data;
        end
    end
endmodule

// ===== test/digital_io_port_8ch_bench.sv
// Purpose: Self-checking bench for the eight-line port over APB
// Assumes: Error settle shortened to 100 cycles
// Notes: Reads of the wait result stall until the wait ends
`timescale 1ns/100ps
`include "dio_defs.svh"
module digital_io_port_8ch_bench;
    import dio_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    addr_t paddr = 8'h00;
    word_t pwdata = 32'h00000000;
    word_t prdata, rd;
    logic pready, pslverr, loop_active, loop_wr_en, module_absent, loop_in_valid, ready, err;
    byte_t loop_wr_data, loop_in, pins, io_out, io_oe;
    byte_t ext = 8'h00;
    byte_t wr_val = 8'h00;
    logic want_loop = 1'b0;
    logic wr_req = 1'b0;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////
    digital_io_port_8ch #(.IN_SYNC(2), .OUT_SYNC(1), .ERR_SETTLE_CYC(100),
        .MODULE_ID(32'h00001234)) DUT (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_active(loop_active), .loop_wr_en(loop_wr_en),
        .loop_wr_data(loop_wr_data), .module_absent(module_absent), .loop_in(loop_in),
        .loop_in_valid(loop_in_valid), .ready(ready), .io_line_n_in(pins),
        .io_line_n_out(io_out), .io_line_n_oe(io_oe));
    loop_partner far_end (
        .pclk(pclk), .presetn(presetn), .want_loop(want_loop), .wr_req(wr_req),
        .wr_val(wr_val), .ext(ext), .ready(ready), .io_out(io_out), .io_oe(io_oe),
        .loop_active(loop_active), .loop_wr_en(loop_wr_en), .loop_wr_data(loop_wr_data),
        .module_absent(module_absent), .pins(pins));
    // Bench runs the block at 125 MHz; keeping host clocks to 40 MHz multiples is the host's duty
    always #4 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run is about 500 cycles; the ceiling leaves ample slack
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input word_t got, input word_t exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input byte_t got, input byte_t exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask
    // Held until pready is sampled; an idle edge follows every transfer
    task automatic apb(input logic w, input addr_t a, input word_t d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input addr_t a, input word_t d);
        apb(1'b1, a, d);
    endtask
    task automatic rdk(input addr_t a, input word_t exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Start a wait, optionally move the lines mid-wait, check done and timeout
    task automatic do_wait(input int ln, input logic [2:0] k, input int tmo, input int dly,
        input byte_t nv, input logic et);
        int t0;
        wr(`OFF_WTMO, word_t'(tmo));
        wr(`OFF_WCMD, word_t'({k, 1'b0, ln[2:0]}));
        t0 = cyc;
        fork
            apb(1'b0, `OFF_WCMD, 32'h0);
            if (dly > 0) begin
                repeat (dly) @(posedge pclk);
                ext <= nv;
            end
        join
        chk(rd & 32'hc, {28'h0, 1'b1, et, 2'b0});
        if (et && tmo > 0) chk(word_t'(cyc - t0 >= tmo && cyc - t0 <= tmo + 6), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Not ready yet: loop data zero, status clear, writes dropped
        chkb(loop_in, 8'h00);
        chkb({7'h0, loop_in_valid}, 8'h00);
        rdk(`OFF_STAT, 32'h0);
        wr(`OFF_BYTE, 32'hff);
        for (int i = 0; i < 400 && ready !== 1'b1; i++) @(posedge pclk);
        @(posedge pclk);
        chkb(io_out, 8'h00);
        rdk(`OFF_STAT, 32'h11);
        rdk(`OFF_DIR, 32'h0);
        rdk(`OFF_ARB, 32'h0);
        rdk(`OFF_ID, 32'h00001234);
        apb(1'b0, 8'h28, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Outputs: data writes never enable, direction per whole port
        wr(`OFF_BYTE, 32'ha5);
        repeat (3) @(posedge pclk);
        chkb(io_oe, 8'h00);
        wr(`OFF_DIR, 32'h1);
        repeat (3) @(posedge pclk);
        chkb(io_oe, 8'h0f);
        chkb(pins, 8'h05);
        wr(`OFF_DIR, 32'h3);
        wr(`OFF_LO, 32'h3);
        wr(`OFF_HI, 32'hc);
        wr(`OFF_LINE, 32'h6);
        repeat (4) @(posedge pclk);
        chkb(io_oe, 8'hff);
        chkb(io_out, 8'h83);
        rdk(`OFF_BYTE, 32'h83);
        // Inputs: ports and a single line read the pins
        wr(`OFF_DIR, 32'h0);
        ext <= 8'h5a;
        repeat (5) @(posedge pclk);
        rdk(`OFF_BYTE, 32'h5a);
        rdk(`OFF_LO, 32'ha);
        rdk(`OFF_HI, 32'h5);
        wr(`OFF_LINE, 32'h101);
        rdk(`OFF_LINE, 32'h1);
        chkb(io_oe, 8'h00);
        // Waits: line 0 starts low, line 1 high
        do_wait(0, `WK_HIGH, 0, 0, 8'h5a, 1'b1);
        do_wait(1, `WK_HIGH, -1, 0, 8'h5a, 1'b0);
        do_wait(0, `WK_LOW, -1, 0, 8'h5a, 1'b0);
        do_wait(0, `WK_RISE, 20, 0, 8'h5a, 1'b1);
        do_wait(1, `WK_FALL, 20, 0, 8'h5a, 1'b1);
        do_wait(0, `WK_HIGH, 40, 8, 8'h5b, 1'b0);
        do_wait(0, `WK_FALL, -1, 8, 8'h5a, 1'b0);
        do_wait(0, `WK_RISE, -1, 8, 8'h5b, 1'b0);
        do_wait(0, `WK_ANY, -1, 8, 8'h5a, 1'b0);
        do_wait(1, `WK_ANY, 30, 0, 8'h5a, 1'b1);
        // Loop path with arbitration on
        wr(`OFF_ARB, 32'h1);
        rdk(`OFF_ARB, 32'h1);
        wr(`OFF_DIR, 32'h3);
        want_loop <= 1'b1;
        for (int i = 0; i < 50 && loop_active !== 1'b1; i++) @(posedge pclk);
        wr_val <= 8'h3c;
        wr_req <= 1'b1;
        @(posedge pclk);
        wr_req <= 1'b0;
        repeat (8) @(posedge pclk);
        chkb(io_out, 8'h3c);
        chkb(loop_in, 8'h3c);
        chkb({7'h0, loop_in_valid}, 8'h01);
        // Collision with arbitration on: APB value first, loop value one cycle later
        fork
            wr(`OFF_BYTE, 32'h11);
            begin
                @(posedge pclk);
                wr_val <= 8'h22;
                wr_req <= 1'b1;
                @(posedge pclk);
                wr_req <= 1'b0;
                repeat (3) @(posedge pclk);
                chkb(io_out, 8'h11);
                @(posedge pclk);
                chkb(io_out, 8'h22);
            end
        join
        // Direction change mid-loop drops ready until the loop stops
        wr(`OFF_DIR, 32'h1);
        repeat (2) @(posedge pclk);
        chkb({7'h0, ready}, 8'h00);
        chkb(io_oe, 8'h00);
        want_loop <= 1'b0;
        for (int i = 0; i < 400 && ready !== 1'b1; i++) @(posedge pclk);
        chkb({7'h0, ready}, 8'h01);
        tally_and_finish();
    end
endmodule
